// File: verilog/adc_ctrl_pkg.sv
// Purpose: Shared constants and types for the successive-approximation converter control block.
// Assumes: One 250 MHz core clock; the converter clock is an enable pulse derived from it.
// Notes:   Register offsets are word indices on the plain register port.
package adc_ctrl_pkg;

  // Register port types.
  typedef logic [1:0] addr_type;
  typedef logic [7:0] byte_type;
  typedef logic [4:0] channel_type;
  typedef logic [2:0] prescale_type;

  // Register offsets.
  localparam addr_type REG_STATUS_CONTROL = 2'h0;
  localparam addr_type REG_DATA           = 2'h1;
  localparam addr_type REG_CLOCK          = 2'h2;

  // Status/control field positions.
  localparam int COCO_BIT    = 7;
  localparam int IRQ_EN_BIT  = 6;
  localparam int CONT_BIT    = 5;
  localparam int CHANNEL_LSB = 0;
  localparam int CHANNEL_MSB = 4;

  // Clock register field positions.
  localparam int PRESCALE_LSB = 5;
  localparam int PRESCALE_MSB = 7;
  localparam int CLK_SRC_BIT  = 4;

  // Channel codes.
  localparam channel_type CHANNEL_POWER_OFF = 5'h1f;
  localparam channel_type CHANNEL_REF_HIGH  = 5'h1d;
  localparam channel_type CHANNEL_REF_LOW   = 5'h1e;
  localparam int          NUM_PINS          = 8;

  // Reset values.
  localparam channel_type  CHANNEL_RESET  = 5'h1f;
  localparam prescale_type PRESCALE_RESET = 3'h0;
  localparam logic         CLK_SRC_RESET  = 1'b0;
  localparam logic         CLK_SRC_BUS    = 1'b1;

  // Conversion timing in converter clock ticks.
  localparam logic [4:0] SAMPLE_TICKS = 5'h08;
  localparam logic [4:0] CONV_TICKS   = 5'h10;
  localparam logic [4:0] LAST_TICK    = 5'h10;
  localparam logic [2:0] MSB_INDEX    = 3'h7;
  localparam byte_type   TRIAL_START  = 8'h80;

  // Recommended converter clock; software sets the divider to approach it.
  localparam int CLK_PERIOD_NS          = 4;
  localparam int ADC_CLOCK_TARGET_NS    = 1000;
  localparam int ADC_TARGET_CORE_CYCLES = ADC_CLOCK_TARGET_NS / CLK_PERIOD_NS;

  // Sequencer phases.
  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_SAMPLE,
    PHASE_CONVERT,
    PHASE_TRANSFER
  } phase_type;

  // Terminal count of the prescaler: divide by 1, 2, 4, 8, or 16 for any code with bit 2 set.
  function automatic logic [3:0] prescale_mask(input prescale_type code);
    logic [3:0] mask;
    mask = 4'hf;
    case (code)
      3'h0:    mask = 4'h0;
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h3:    mask = 4'h7;
      default: mask = 4'hf;
    endcase
    return mask;
  endfunction

endpackage

// File: verilog/adc_clock_divider.sv
// Purpose: Makes the one-cycle converter clock enable from the bus clock or the oscillator input.
// Assumes: The oscillator input is synchronous to core_clk and well below its rate.
// Notes:   The bus source gives an input tick every core cycle.
`timescale 1ns/100ps
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       source_select,
  input  wire logic                       oscillator_clock,
  input  wire adc_ctrl_pkg::prescale_type prescale,
  output logic                            adc_tick
);

  typedef struct packed {
    logic       osc_prev;
    logic [3:0] count;
    logic       tick;
  } divider_state_type;

  divider_state_type s;
  divider_state_type next_s;
  logic              in_tick;

  // Chooses the input clock and divides it by the programmed ratio.
  always_comb begin
    next_s = s;
    next_s.osc_prev = oscillator_clock;
    next_s.tick = 1'b0;
    in_tick = (source_select == CLK_SRC_BUS) ? 1'b1 : (oscillator_clock & ~s.osc_prev);
    if (in_tick) begin
      if (s.count >= prescale_mask(prescale)) begin
        next_s.count = 4'h0;
        next_s.tick = 1'b1;
      end else begin
        next_s.count = s.count + 4'h1;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign adc_tick = s.tick;

endmodule

// File: verilog/adc_conversion_control.sv
// Purpose: Control logic for an 8-bit successive-approximation converter with eight shared pins.
// Assumes: The analog comparator answers compare_high within one converter tick of a code change.
// Notes:   Register reads answer in the next cycle; writes take effect at the next edge.
// Function
// - Status/control write starts a new conversion.
// - Conversion lasts 16 to 17 converter ticks.
// - Continuous mode overwrites result every conversion.
// - Continuous mode repeats until bit cleared.
// - Continuous flag holds until write or read.
// - Single mode converts once per write.
// - Selected pin forced to input for converter.
// - Port writes ignored on selected pin.
// - Port read of selected pin returns 0.
// - Unselected pins stay normal port pins.
// - High reference gives ff, low gives 00.
// - Eight-bit result from eight multiplexed channels.
// - Completion stores result, sets flag or interrupt.
// - Interrupt enabled requests after every conversion.
// - Flag not completion indicator with interrupts.
// - Monotonic codes, none skipped.
// - Continuous bit one repeats, zero single.
// - Five-bit channel field; all ones powers off.
// - Clock source select and 1-16 prescaler.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire adc_ctrl_pkg::addr_type    reg_addr,
  input  wire adc_ctrl_pkg::byte_type    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output adc_ctrl_pkg::byte_type         reg_rdata,
  input  wire logic                      oscillator_clock,
  input  wire logic                      compare_high,
  input  wire adc_ctrl_pkg::byte_type    port_out_reg,
  input  wire adc_ctrl_pkg::byte_type    port_dir,
  input  wire adc_ctrl_pkg::byte_type    pin_in,
  output adc_ctrl_pkg::byte_type         pin_out,
  output adc_ctrl_pkg::byte_type         pin_oe_b,
  output adc_ctrl_pkg::byte_type         port_read_data,
  output adc_ctrl_pkg::channel_type      channel_select,
  output logic                           converter_power_on,
  output logic                           sample_enable,
  output adc_ctrl_pkg::byte_type         sar_code,
  output logic                           converter_busy,
  output logic                           conversion_irq
);

  typedef struct packed {
    phase_type    phase;
    logic [4:0]   ticks;
    logic [2:0]   bit_idx;
    byte_type     trial;
    byte_type     result;
    logic         start_pending;
    logic         coco;
    logic         irq;
    logic         first_done;
    logic         irq_en;
    logic         continuous;
    channel_type  channel;
    prescale_type prescale;
    logic         clk_src;
    byte_type     rdata;
    byte_type     pin_out;
    byte_type     pin_oe_b;
    byte_type     port_read;
    logic         power_on;
    logic         sampling;
    logic         busy;
  } ctrl_state_type;

  localparam ctrl_state_type STATE_RESET = '{
    phase:         PHASE_IDLE,
    ticks:         5'h00,
    bit_idx:       3'h0,
    trial:         8'h00,
    result:        8'h00,
    start_pending: 1'b0,
    coco:          1'b0,
    irq:           1'b0,
    first_done:    1'b0,
    irq_en:        1'b0,
    continuous:    1'b0,
    channel:       CHANNEL_RESET,
    prescale:      PRESCALE_RESET,
    clk_src:       CLK_SRC_RESET,
    rdata:         8'h00,
    pin_out:       8'h00,
    pin_oe_b:      8'hff,
    port_read:     8'h00,
    power_on:      1'b0,
    sampling:      1'b0,
    busy:          1'b0
  };

  ctrl_state_type s;
  ctrl_state_type next_s;
  logic           adc_tick;
  logic           status_wr;
  logic           clock_wr;
  logic           data_rd;
  logic           conv_end;
  logic           pin_hit;

  // Converter clock enable from the selected source and prescaler.
  adc_clock_divider u_divider (
    .core_clk         (core_clk),
    .rst_b            (rst_b),
    .source_select    (s.clk_src),
    .oscillator_clock (oscillator_clock),
    .prescale         (s.prescale),
    .adc_tick         (adc_tick)
  );

  // Decodes the register strobes.
  assign status_wr = reg_wr && (reg_addr == REG_STATUS_CONTROL);
  assign clock_wr  = reg_wr && (reg_addr == REG_CLOCK);
  assign data_rd   = reg_rd && (reg_addr == REG_DATA);
  assign conv_end  = adc_tick && !status_wr && (s.phase == PHASE_TRANSFER);

  // Next-state logic: register access, sequencer, and pin override.
  always_comb begin
    next_s = s;
    pin_hit = 1'b0;
    next_s.rdata = 8'h00;
    // Read data; unmapped offsets read as zero. The flag reads 0 while interrupts are on.
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS_CONTROL: next_s.rdata = {s.coco & ~s.irq_en, s.irq_en, s.continuous, s.channel};
        REG_DATA:           next_s.rdata = s.result;
        REG_CLOCK:          next_s.rdata = {s.prescale, s.clk_src, 4'h0};
        default:            next_s.rdata = 8'h00;
      endcase
    end
    // A data read or a control write clears the flag and the interrupt request.
    if (status_wr || data_rd) begin
      next_s.coco = 1'b0;
      next_s.irq = 1'b0;
    end
    if (clock_wr) begin
      next_s.prescale = reg_wdata[PRESCALE_MSB:PRESCALE_LSB];
      next_s.clk_src = reg_wdata[CLK_SRC_BIT];
    end
    if (status_wr) begin
      // A control write aborts any conversion and arms a new one unless powering off.
      next_s.irq_en = reg_wdata[IRQ_EN_BIT];
      next_s.continuous = reg_wdata[CONT_BIT];
      next_s.channel = reg_wdata[CHANNEL_MSB:CHANNEL_LSB];
      next_s.phase = PHASE_IDLE;
      next_s.first_done = 1'b0;
      next_s.start_pending = (reg_wdata[CHANNEL_MSB:CHANNEL_LSB] != CHANNEL_POWER_OFF);
    end else if (adc_tick) begin
      case (s.phase)
        PHASE_IDLE: begin
          // The pending start is held until the first converter tick takes it.
          if (s.start_pending) begin
            next_s.start_pending = 1'b0;
            next_s.phase = PHASE_SAMPLE;
            next_s.ticks = 5'h01;
            next_s.trial = 8'h00;
          end
        end
        PHASE_SAMPLE: begin
          next_s.ticks = s.ticks + 5'h01;
          if (s.ticks + 5'h01 == SAMPLE_TICKS) begin
            next_s.phase = PHASE_CONVERT;
            next_s.trial = TRIAL_START;
            next_s.bit_idx = MSB_INDEX;
          end
        end
        PHASE_CONVERT: begin
          // Keep the trial bit when the input is at or above the trial code.
          next_s.ticks = s.ticks + 5'h01;
          if (!compare_high) begin
            next_s.trial[s.bit_idx] = 1'b0;
          end
          if (s.bit_idx != 3'h0) begin
            next_s.trial[3'(s.bit_idx - 3'h1)] = 1'b1;
            next_s.bit_idx = s.bit_idx - 3'h1;
          end else begin
            next_s.phase = PHASE_TRANSFER;
          end
        end
        PHASE_TRANSFER: begin
          // Store the result, then flag or interrupt; the set wins over a same-cycle read clear.
          next_s.ticks = s.ticks + 5'h01;
          next_s.result = s.trial;
          if (s.irq_en) begin
            next_s.irq = 1'b1;
          end else if (!(s.continuous && s.first_done)) begin
            next_s.coco = 1'b1;
          end
          next_s.first_done = 1'b1;
          if (s.continuous) begin
            next_s.phase = PHASE_SAMPLE;
            next_s.ticks = 5'h01;
            next_s.trial = 8'h00;
          end else begin
            next_s.phase = PHASE_IDLE;
          end
        end
        default: begin
          next_s.phase = PHASE_IDLE;
        end
      endcase
    end
    // The selected pin is released from the port and reads zero; the rest follow the port.
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_hit = (s.channel == 5'(i));
      next_s.pin_out[i] = pin_hit ? 1'b0 : port_out_reg[i];
      next_s.pin_oe_b[i] = pin_hit ? 1'b1 : ~port_dir[i];
      next_s.port_read[i] = pin_hit ? 1'b0 : (port_dir[i] ? port_out_reg[i] : pin_in[i]);
    end
    next_s.power_on = (next_s.channel != CHANNEL_POWER_OFF);
    next_s.sampling = (next_s.phase == PHASE_SAMPLE);
    next_s.busy = (next_s.phase != PHASE_IDLE) || next_s.start_pending;
  end

  // Registers the whole control state.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata          = s.rdata;
  assign pin_out            = s.pin_out;
  assign pin_oe_b           = s.pin_oe_b;
  assign port_read_data     = s.port_read;
  assign channel_select     = s.channel;
  assign converter_power_on = s.power_on;
  assign sample_enable      = s.sampling;
  assign sar_code           = s.trial;
  assign converter_busy     = s.busy;
  assign conversion_irq     = s.irq;

  // Checks on the control sequence.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence seq_conv_end;
    conv_end;
  endsequence

  sequence seq_quiet;
    !status_wr && !data_rd;
  endsequence

  chk_start_armed: assert property (status_wr && reg_wdata[CHANNEL_MSB:CHANNEL_LSB] != CHANNEL_POWER_OFF |=> s.start_pending && s.phase == PHASE_IDLE)
    else $error("Control write did not arm a conversion.");

  chk_conv_length: assert property (seq_conv_end |-> s.ticks == LAST_TICK)
    else $error("Conversion did not span sixteen converter ticks.");

  chk_result_stored: assert property (seq_conv_end |=> s.result == $past(s.trial))
    else $error("Result register not loaded at conversion end.");

  chk_cont_restart: assert property (seq_conv_end ##0 s.continuous |=> s.phase == PHASE_SAMPLE && s.ticks == 5'h01)
    else $error("Continuous mode did not start the next conversion.");

  chk_coco_hold: assert property (s.coco ##0 seq_quiet |=> s.coco)
    else $error("Completion flag dropped without a clear.");

  chk_single_idle: assert property (seq_conv_end ##0 !s.continuous ##1 (!status_wr)[*2] |-> s.phase == PHASE_IDLE && !s.busy)
    else $error("Single mode did not return to idle.");

  chk_pin_released: assert property (s.channel < 5'h08 |=> s.pin_oe_b[$past(s.channel[2:0])] && port_read_data[$past(s.channel[2:0])] == 1'b0)
    else $error("Selected pin still driven or readable.");

  chk_irq_raised: assert property (seq_conv_end ##0 s.irq_en && !data_rd |=> conversion_irq ##1 (conversion_irq || $past(data_rd || status_wr)))
    else $error("Interrupt not raised after conversion.");

  chk_flag_masked: assert property (reg_rd && reg_addr == REG_STATUS_CONTROL && s.irq_en |=> !reg_rdata[COCO_BIT])
    else $error("Completion flag visible with interrupts enabled.");

  chk_bit_order: assert property (adc_tick && !status_wr && s.phase == PHASE_CONVERT && s.bit_idx != 3'h0 |=> s.trial[s.bit_idx])
    else $error("Next lower trial bit not set.");

  chk_power_off: assert property (status_wr && reg_wdata[CHANNEL_MSB:CHANNEL_LSB] == CHANNEL_POWER_OFF |=> !converter_busy && !converter_power_on)
    else $error("Power-off write left the converter running.");

  chk_coco_single: assert property (seq_conv_end ##0 !s.irq_en && !s.continuous |=> s.coco)
    else $error("Single conversion did not set the completion flag.");

  chk_other_pins: assert property (s.channel >= 5'h08 |=> pin_oe_b == ~$past(port_dir) && pin_out == $past(port_out_reg))
    else $error("Port pins not under port control with no pin selected.");

  chk_msb_trial: assert property (adc_tick && !status_wr && s.phase == PHASE_SAMPLE && s.ticks + 5'h01 == SAMPLE_TICKS |=> sar_code == TRIAL_START)
    else $error("Conversion did not open with the top trial bit.");

  chk_irq_clear: assert property (conversion_irq && data_rd && !conv_end |=> !conversion_irq)
    else $error("Data read did not clear the interrupt request.");

endmodule

// File: sim/analog_source_model.sv
// Purpose: Behavioural stand-in for the analog pins, references and comparator.
// Assumes: Each pin level is given as the ideal code that the pin voltage equals.
// Notes:   The level is held from the sampling phase, as a sample-and-hold would.
`timescale 1ns/100ps
module analog_source_model
  import adc_ctrl_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire adc_ctrl_pkg::channel_type channel_select,
  input  wire logic                      sample_enable,
  input  wire adc_ctrl_pkg::byte_type    sar_code,
  input  wire logic [63:0]               pin_levels,
  output logic                           compare_high
);
  byte_type held;
  byte_type live;

  // Picks the level of the chosen pin or reference; reserved codes read as low.
  always_comb begin
    live = 8'h00;
    if (channel_select < 5'h08) begin
      live = pin_levels[8 * channel_select[2:0] +: 8];
    end else if (channel_select == CHANNEL_REF_HIGH) begin
      live = 8'hff;
    end
  end

  // Tracks the input only while sampling, so later changes cannot leak in.
  always @(posedge core_clk) begin
    if (sample_enable) begin
      held <= live;
    end
  end

  // Comparator answer for the present trial code.
  assign compare_high = (held >= sar_code);
endmodule

// File: sim/sar_adc_conversion_control_bench.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: The oscillator input rises once every four core cycles.
// Notes:   Conversion lengths are checked against a window in core cycles.
`timescale 1ns/100ps
module sar_adc_conversion_control_bench;
  import adc_ctrl_pkg::*;
  logic        core_clk, rst_b, reg_wr, reg_rd, compare_high;
  addr_type    reg_addr;
  byte_type    reg_wdata, reg_rdata, port_out_reg, port_dir, pin_in, pin_out, pin_oe_b, port_read_data, sar_code, d;
  channel_type channel_select;
  logic        converter_power_on, sample_enable, converter_busy, conversion_irq;
  logic [1:0]  osc_cnt;
  logic [63:0] lv;
  int          n_mismatch, tests_run, n;

  // Core clock, 4 ns period.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Free-running oscillator input at a quarter of the core rate.
  always @(posedge core_clk) osc_cnt <= rst_b ? osc_cnt + 2'h1 : 2'h0;

  adc_conversion_control uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oscillator_clock(osc_cnt[1]),
    .compare_high(compare_high), .port_out_reg(port_out_reg), .port_dir(port_dir), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_b(pin_oe_b), .port_read_data(port_read_data), .channel_select(channel_select),
    .converter_power_on(converter_power_on), .sample_enable(sample_enable), .sar_code(sar_code),
    .converter_busy(converter_busy), .conversion_irq(conversion_irq));

  analog_source_model model (.core_clk(core_clk), .channel_select(channel_select), .sample_enable(sample_enable),
    .sar_code(sar_code), .pin_levels(lv), .compare_high(compare_high));

  // Compares one value and counts it.
  task automatic chk(input byte_type seen, input byte_type exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Ends the run when a wait is used up.
  task automatic hang();
    n_mismatch++;
    $display("ERROR at %0t: wait ran out", $time);
    wrap_up();
  endtask

  // One-cycle register write.
  task automatic wr(input addr_type a, input byte_type v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; data are taken in the following cycle.
  task automatic rd(input addr_type a, output byte_type v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Waits for the busy flag to drop, counting cycles.
  task automatic wait_idle(input int lim);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (converter_busy !== 1'b0 && n < lim);
    if (converter_busy !== 1'b0) hang();
  endtask

  // Waits for the interrupt request.
  task automatic wait_irq();
    n = 0;
    while (conversion_irq !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 2000) hang();
    end
  endtask

  // Checks the pad and port-read views for the selected-pin mask m.
  task automatic chk_pins(input byte_type m);
    chk(pin_oe_b, ~port_dir | m);
    chk(pin_out, port_out_reg & ~m);
    chk(port_read_data, ((port_dir & port_out_reg) | (~port_dir & pin_in)) & ~m);
  endtask

  // Single conversion of channel c at level v, k core cycles per converter tick.
  task automatic convert(input int c, input byte_type v, input int k);
    if (c < 8) lv[8 * c +: 8] <= v;
    wr(REG_STATUS_CONTROL, byte_type'(c));
    wait_idle(30 * k + 50);
    chk(byte_type'(n >= 16 * k && n <= 18 * k + 4), 8'h01);
    rd(REG_STATUS_CONTROL, d);
    chk(d, 8'h80 | byte_type'(c));
    rd(REG_DATA, d);
    chk(d, v);
  endtask

  // Reset values, unmapped index and idle pins.
  task automatic t_reset();
    rd(REG_STATUS_CONTROL, d);
    chk(d, 8'h1f);
    rd(REG_CLOCK, d);
    chk(d, 8'h00);
    rd(2'h3, d);
    chk(d, 8'h00);
    chk(byte_type'(converter_power_on), 8'h00);
    chk_pins(8'h00);
    $display("done: reset");
  endtask

  // Single conversion, flag, read-only data, port override and idling.
  task automatic t_single();
    wr(REG_CLOCK, 8'h10);
    convert(2, 8'h5a, 1);
    chk_pins(8'h04);
    @(posedge core_clk);
    port_out_reg <= 8'hff;
    port_dir <= 8'hff;
    repeat (3) @(posedge core_clk);
    #1;
    chk_pins(8'h04);
    rd(REG_STATUS_CONTROL, d);
    chk(d, 8'h02);
    wr(REG_DATA, 8'h00);
    rd(REG_DATA, d);
    chk(d, 8'h5a);
    repeat (60) @(posedge core_clk);
    #1;
    chk(byte_type'(converter_busy), 8'h00);
    $display("done: single");
  endtask

  // Codes across every pin and both references.
  task automatic t_codes();
    byte_type tv [10] = '{8'h00, 8'hff, 8'h01, 8'hfe, 8'h7f, 8'h80, 8'h55, 8'haa, 8'hff, 8'h00};
    for (int i = 0; i < 10; i++) begin
      convert(i < 8 ? i : i + 21, tv[i], 1);
    end
    $display("done: codes");
  endtask

  // Continuous conversions with overwrite and a single flag.
  task automatic t_cont();
    lv[40 +: 8] <= 8'h33;
    wr(REG_STATUS_CONTROL, 8'h25);
    d = 8'h00;
    for (int i = 0; i < 300 && d[7] !== 1'b1; i++) rd(REG_STATUS_CONTROL, d);
    chk(d, 8'ha5);
    rd(REG_DATA, d);
    chk(d, 8'h33);
    lv[40 +: 8] <= 8'hc4;
    repeat (60) @(posedge core_clk);
    rd(REG_DATA, d);
    chk(d, 8'hc4);
    rd(REG_STATUS_CONTROL, d);
    chk(d, 8'h25);
    chk(byte_type'(converter_busy), 8'h01);
    wr(REG_STATUS_CONTROL, 8'h05);
    wait_idle(200);
    repeat (60) @(posedge core_clk);
    #1;
    chk(byte_type'(converter_busy), 8'h00);
    $display("done: continuous");
  endtask

  // Interrupt per conversion, flag masked, then power-off.
  task automatic t_irq();
    lv[48 +: 8] <= 8'h9c;
    wr(REG_STATUS_CONTROL, 8'h46);
    wait_irq();
    rd(REG_STATUS_CONTROL, d);
    chk(d, 8'h46);
    rd(REG_DATA, d);
    chk(d, 8'h9c);
    chk(byte_type'(conversion_irq), 8'h00);
    wr(REG_STATUS_CONTROL, 8'h66);
    wait_irq();
    rd(REG_DATA, d);
    chk(d, 8'h9c);
    wait_irq();
    wr(REG_STATUS_CONTROL, 8'h1f);
    repeat (60) @(posedge core_clk);
    #1;
    chk(byte_type'({converter_power_on, converter_busy, conversion_irq}), 8'h00);
    $display("done: interrupt");
  endtask

  // Oscillator source and two divide ratios.
  task automatic t_clock();
    wr(REG_CLOCK, 8'h20);
    convert(0, 8'h42, 8);
    wr(REG_CLOCK, 8'h90);
    rd(REG_CLOCK, d);
    chk(d, 8'h90);
    convert(7, 8'hbd, 16);
    $display("done: clock");
  endtask

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    port_out_reg = 8'ha5;
    port_dir = 8'h0f;
    pin_in = 8'hff;
    lv = 64'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_single();
    t_codes();
    t_cont();
    t_irq();
    t_clock();
    wrap_up();
  end
endmodule
